/* fcedc_pkg.sv */
// Shared constants and types for the line coding endec core
package fcedc_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int unsigned WORD_W  = 32;
  localparam int unsigned EXT_W   = 8;
  localparam int unsigned ENC_W   = 40;
  localparam int unsigned CHUNK_W = 20;
  localparam int unsigned OS_N    = 15;
  // ****************************************
  // Line code tables, first running disparity
  // ****************************************
  localparam logic [5:0] TBL6 [0:31] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] TBL4 [0:7] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  localparam logic [5:0] K28_6B   = 6'h0f;
  localparam logic [4:0] K28_IDX  = 5'h1c;
  localparam logic [3:0] A7_4B    = 4'h7;
  localparam logic [3:0] X3_4B    = 4'hc;
  localparam logic [5:0] D7_6B    = 6'h38;
  localparam logic [6:0] COMMA_P  = 7'h1f;
  localparam logic [7:0] K28_5    = 8'hbc;
  localparam logic [7:0] K28_4    = 8'h9c;
  // ****************************************
  // Check word and ordered set lines
  // ****************************************
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT = 32'h00000000;
  localparam int OS_SOF = 0, OS_EOF = 1, OS_IDLE = 2, OS_RRDY = 3;
  localparam int OS_OLS = 4, OS_NOS = 5, OS_LR = 6, OS_LRR = 7;
  localparam int OS_ARB = 8, OS_OPN = 9, OS_CLS = 10, OS_MRK = 11;
  localparam int OS_LIP = 12, OS_LPE = 13, OS_LPB = 14;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    SY_LOS0 = 3'h0, SY_LOS1 = 3'h1, SY_LOS2 = 3'h2, SY_OK = 3'h3,
    SY_BAD1 = 3'h4, SY_BAD2 = 3'h5, SY_BAD3 = 3'h6
  } fcedc_sync_t;
  typedef struct packed {
    logic       rd;
    logic       inv;
    logic       rderr;
    logic       k;
    logic [7:0] b;
  } fcedc_chr_t;
  typedef struct packed {
    logic        rd;
    logic        inv;
    logic        rderr;
    logic        k;
    logic [31:0] w;
  } fcedc_dec_t;
  typedef struct packed {
    logic [31:0] w;
    logic        k;
  } fcedc_txw_t;
endpackage : fcedc_pkg

/* fcedc_core.sv */
// Line coding endec core: transmit encode path and receive decode path
//
// Summary of operation
// - Without bypass, take a 32-bit word and encode it to 40 bits.
// - Special flag encodes the top byte as a K character.
// - Encoded word leaves in 20-bit pieces, 10-bit in narrow mode.
// - Check generator runs from SOF to any ordered set, then inserts.
// - With in-frame idle on, IDLE neither stops nor alters the check.
// - Bypass joins 8 raw bits and 32 data bits, no coding or check.
// - Provide a half-rate transmit clock from the full-rate system clock.
// - Reset synchronised separately into transmit and receive resets.
// - Clock stop input halts both half-rate clocks.
// - Each edge captures 20 bits, or 10 in narrow mode.
// - Receive half-rate clock is full rate divided by two.
// - Without bypass, decode to a 32-bit word, extension unused.
// - Special flag marks a K28 character in the top byte.
// - Checker starts after SOF; IDLE ignored when in-frame idle on.
// - Frame end pulses check done for one word: one half-rate cycle, two in narrow mode.
// - Check good with done only when the remainder is zero.
// - Receive bypass passes raw bits to word and extension outputs.
// - Reset enters loss of sync; index bus shows the state.
// - Three valid command characters in loss of sync give sync.
// - Four invalid words in a row while in sync lose sync.
// - Recognise 15 ordered set kinds, one line asserted each.
// - Flag invalid codes and running disparity errors per word.
// - Line order SOF EOF IDLE RRDY OLS NOS LR LRR ARB OPN CLS MRK ...
`timescale 1ns/1ps
`default_nettype none
module fcedc_core (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        clk_stop_i,
  input  wire logic        narrow_iface_sel_i,
  // Transmit user side
  input  wire logic        tx_bypass_sel_i,
  input  wire logic [31:0] tx_word_in_i,
  input  wire logic [7:0]  tx_raw_ext_in_i,
  input  wire logic        tx_special_flag_i,
  input  wire logic        tx_check_gen_on_i,
  input  wire logic        tx_inframe_idle_on_i,
  output logic             tx_ready_o,
  output logic             tx_taken_o,
  output logic             tx_half_rate_clk_o,
  output logic             tx_path_reset_o,
  // Serializer side
  output logic [19:0]      ser_chunk_out_o,
  input  wire logic [19:0] des_chunk_in_i,
  // Receive user side
  input  wire logic        rx_bypass_sel_i,
  input  wire logic        rx_check_on_i,
  input  wire logic        rx_inframe_idle_on_i,
  output logic             rx_half_rate_clk_o,
  output logic             rx_path_reset_o,
  output logic             rx_word_valid_o,
  output logic [31:0]      rx_word_out_o,
  output logic [7:0]       rx_raw_ext_out_o,
  output logic             rx_special_flag_o,
  output logic             rx_check_done_o,
  output logic             rx_check_good_o,
  output logic             sync_lost_flag_o,
  output logic [2:0]       sync_state_index_o,
  output logic [14:0]      ordered_set_onehot_o,
  output logic             bad_code_flag_o,
  output logic             disparity_error_flag_o
);
  // ****************************************
  // Functions
  // ****************************************
  // Encode one byte at the given running disparity
  function automatic logic [10:0] enc_char(input logic [7:0] b,
                                           input logic k, input logic rd);
    logic [5:0] c6;
    logic [3:0] c4;
    logic       r;
    c6 = k ? fcedc_pkg::K28_6B : fcedc_pkg::TBL6[b[4:0]];
    if (rd && ($countones(c6) != 3 || c6 == fcedc_pkg::D7_6B)) c6 = ~c6;
    r = rd ^ ($countones(c6) != 3);
    c4 = fcedc_pkg::TBL4[b[7:5]];
    if (!k && b[7:5] == 3'h7 &&
        ((!r && (b[4:0] == 5'h11 || b[4:0] == 5'h12 || b[4:0] == 5'h14)) ||
         (r && (b[4:0] == 5'h0b || b[4:0] == 5'h0d || b[4:0] == 5'h0e))))
      c4 = fcedc_pkg::A7_4B;
    if (r && ($countones(c4) != 2 || c4 == fcedc_pkg::X3_4B)) c4 = ~c4;
    if (k && !r && $countones(c4) == 2 && c4 != fcedc_pkg::X3_4B) c4 = ~c4;
    return {r ^ ($countones(c4) != 2), c6, c4};
  endfunction : enc_char

  // Encode a word, top byte first in the top bits
  function automatic logic [40:0] enc_word(input logic [31:0] w,
                                           input logic k, input logic rd);
    logic [40:0] o;
    logic [10:0] c;
    o = '0;
    o[40] = rd;
    for (int i = 3; i >= 0; i--) begin
      c = enc_char(w[8*i +: 8], k && i == 3, o[40]);
      o[40] = c[10];
      o[10*i +: 10] = c[9:0];
    end
    return o;
  endfunction : enc_word

  // Decode one character with code and disparity checks
  function automatic fcedc_pkg::fcedc_chr_t dec_char(input logic [9:0] c,
                                                    input logic rd);
    fcedc_pkg::fcedc_chr_t o;
    logic [5:0] c6;
    logic [3:0] c4;
    logic       f6;
    logic       f4;
    logic       r;
    o = '0;
    c6 = c[9:4];
    c4 = c[3:0];
    f6 = 1'b0;
    f4 = 1'b0;
    o.k = c6 == fcedc_pkg::K28_6B || c6 == ~fcedc_pkg::K28_6B;
    for (int i = 0; i < 32; i++)
      if (c6 == fcedc_pkg::TBL6[i] || (c6 == ~fcedc_pkg::TBL6[i] &&
          ($countones(fcedc_pkg::TBL6[i]) != 3 || i == 7))) begin
        o.b[4:0] = 5'(i);
        f6 = 1'b1;
      end
    if (o.k) begin
      o.b[4:0] = fcedc_pkg::K28_IDX;
      f6 = 1'b1;
    end
    if (c6 == ~fcedc_pkg::K28_6B) c4 = ~c4;
    for (int j = 0; j < 8; j++)
      if (c4 == fcedc_pkg::TBL4[j] || (c4 == ~fcedc_pkg::TBL4[j] &&
          ($countones(fcedc_pkg::TBL4[j]) != 2 || j == 3))) begin
        o.b[7:5] = 3'(j);
        f4 = 1'b1;
      end
    if (c4 == fcedc_pkg::A7_4B || c4 == ~fcedc_pkg::A7_4B) begin
      o.b[7:5] = 3'h7;
      f4 = 1'b1;
    end
    o.inv = !(f6 && f4);
    o.rderr = (rd && $countones(c6) > 3) || (!rd && $countones(c6) < 3);
    r = ($countones(c6) == 3) ? rd : ($countones(c6) > 3);
    o.rderr = o.rderr || (r && $countones(c[3:0]) > 2) ||
              (!r && $countones(c[3:0]) < 2);
    o.rd = ($countones(c[3:0]) == 2) ? r : ($countones(c[3:0]) > 2);
    return o;
  endfunction : dec_char

  // Decode a 40-bit word, top character first
  function automatic fcedc_pkg::fcedc_dec_t dec_word(input logic [39:0] e,
                                                    input logic rd);
    fcedc_pkg::fcedc_dec_t o;
    fcedc_pkg::fcedc_chr_t c;
    o = '0;
    o.rd = rd;
    for (int i = 3; i >= 0; i--) begin
      c = dec_char(e[10*i +: 10], o.rd);
      o.rd = c.rd;
      o.inv = o.inv | c.inv;
      o.rderr = o.rderr | c.rderr;
      o.w[8*i +: 8] = c.b;
      if (i == 3) o.k = c.k;
    end
    return o;
  endfunction : dec_word

  // One-hot ordered set class of a word
  function automatic logic [14:0] os_class(input logic [31:0] w,
                                           input logic k, input logic idl);
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [23:0] t;
    logic [14:0] m;
    b1 = w[23:16];
    b2 = w[15:8];
    t = w[23:0];
    m = '0;
    if (k && w[31:24] == fcedc_pkg::K28_5) begin
      m[fcedc_pkg::OS_SOF] = b1 == 8'hb5 && b2 == w[7:0] &&
        (b2 == 8'h17 || b2 == 8'h57 || b2 == 8'h37 || b2 == 8'h55 ||
         b2 == 8'h35 || b2 == 8'h56 || b2 == 8'h36 || b2 == 8'h58);
      m[fcedc_pkg::OS_EOF] = (b1 == 8'h95 || b1 == 8'hb5 || b1 == 8'h8a ||
        b1 == 8'haa) && b2 == w[7:0] &&
        (b2 == 8'h75 || b2 == 8'h95 || b2 == 8'hf5 || b2 == 8'hd5);
      m[fcedc_pkg::OS_IDLE] = t == 24'h95b5b5 || (t == 24'hb5b5b5 && idl);
      m[fcedc_pkg::OS_RRDY] = t == 24'h954a4a;
      m[fcedc_pkg::OS_OLS] = t == 24'h358a55;
      m[fcedc_pkg::OS_NOS] = t == 24'h55bf45;
      m[fcedc_pkg::OS_LR] = t == 24'h49bf49;
      m[fcedc_pkg::OS_LRR] = t == 24'h35bf49;
      m[fcedc_pkg::OS_ARB] = b1 == 8'h4a;
      m[fcedc_pkg::OS_OPN] = b1 == 8'h91;
      m[fcedc_pkg::OS_CLS] = t == 24'h85b5b5;
      m[fcedc_pkg::OS_MRK] = b1 == 8'h5f;
      m[fcedc_pkg::OS_LIP] = b1 == 8'h15;
      m[fcedc_pkg::OS_LPE] = b1 == 8'h05;
      m[fcedc_pkg::OS_LPB] = b1 == 8'h09;
    end else if (k && w[31:24] == fcedc_pkg::K28_4 && t == 24'h4af0f0) begin
      m[fcedc_pkg::OS_ARB] = 1'b1;
    end
    return m;
  endfunction : os_class

  // Check word update over one word, top bit first
  function automatic logic [31:0] crc_upd(input logic [31:0] c,
                                          input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--)
      r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? fcedc_pkg::CRC_POLY : '0);
    return r;
  endfunction : crc_upd

  // ****************************************
  // Resets and half-rate clocks
  // ****************************************
  logic tx_rs1_ff, tx_rst_ff, rx_rs1_ff, rx_rst_ff;
  logic tx_hclk_ff, rx_hclk_ff;

  // Separate two-stage reset synchronisers
  always_ff @(posedge sys_clk_i) begin
    tx_rs1_ff <= rst_i;
    tx_rst_ff <= tx_rs1_ff;
    rx_rs1_ff <= rst_i;
    rx_rst_ff <= rx_rs1_ff;
  end

  // Divide by two, frozen by clock stop
  always_ff @(posedge sys_clk_i) begin
    if (tx_rst_ff) tx_hclk_ff <= 1'b0;
    else if (!clk_stop_i) tx_hclk_ff <= ~tx_hclk_ff;
    if (rx_rst_ff) rx_hclk_ff <= 1'b0;
    else if (!clk_stop_i) rx_hclk_ff <= ~rx_hclk_ff;
  end

  // ****************************************
  // Transmit path
  // ****************************************
  logic [1:0]  tx_ph_ff;
  logic [39:0] tx_enc_ff;
  logic        tx_rd_ff, tx_pend_ff, tx_infr_ff, tx_rdy_ff, tx_tkn_ff;
  logic [31:0] tx_crc_ff;
  logic [19:0] ser_ff;
  fcedc_pkg::fcedc_txw_t tx_hold_ff;

  // Word slot, source selection and encoding
  wire [1:0]  tx_last  = narrow_iface_sel_i ? 2'h3 : 2'h1;
  wire        tx_end_s = tx_ph_ff == tx_last;
  wire        tx_take  = tx_end_s && !tx_pend_ff;
  wire        tx_raw   = tx_bypass_sel_i && !tx_pend_ff;
  wire        tx_gen   = tx_check_gen_on_i && !tx_bypass_sel_i;
  wire [14:0] tx_os    = os_class(tx_word_in_i, tx_special_flag_i,
                                  tx_inframe_idle_on_i);
  wire        tx_skip  = tx_os[fcedc_pkg::OS_IDLE] && tx_inframe_idle_on_i;
  wire        tx_ins   = tx_take && tx_gen && tx_infr_ff &&
                         (|tx_os) && !tx_skip;
  wire [31:0] tx_sel_w = tx_pend_ff ? tx_hold_ff.w :
                         tx_ins ? tx_crc_ff : tx_word_in_i;
  wire        tx_sel_k = tx_pend_ff ? tx_hold_ff.k :
                         !tx_ins && tx_special_flag_i;
  wire [40:0] tx_enc   = enc_word(tx_sel_w, tx_sel_k, tx_rd_ff);
  wire        nxt_pend = tx_end_s ? tx_ins : tx_pend_ff;
  wire [9:0]  tx_nchr  = tx_enc_ff[(3 - int'(tx_ph_ff)) * 10 +: 10];
  wire [19:0] nxt_ser  = narrow_iface_sel_i ? {10'h000, tx_nchr} :
                         tx_ph_ff[0] ? tx_enc_ff[19:0] : tx_enc_ff[39:20];

  // Slot counter, output word register and pieces
  always_ff @(posedge sys_clk_i) begin
    if (tx_rst_ff) begin
      tx_ph_ff   <= 2'h0;
      tx_enc_ff  <= '0;
      tx_rd_ff   <= 1'b0;
      tx_pend_ff <= 1'b0;
      tx_hold_ff <= '0;
      tx_rdy_ff  <= 1'b1;
      tx_tkn_ff  <= 1'b0;
      ser_ff     <= '0;
    end else begin
      tx_ph_ff  <= tx_end_s ? 2'h0 : tx_ph_ff + 2'h1;
      ser_ff    <= nxt_ser;
      tx_tkn_ff <= tx_take;
      tx_rdy_ff <= !nxt_pend;
      tx_pend_ff <= nxt_pend;
      if (tx_take) tx_hold_ff <= {tx_word_in_i, tx_special_flag_i};
      if (tx_end_s) begin
        tx_enc_ff <= tx_raw ? {tx_raw_ext_in_i, tx_word_in_i}
                            : tx_enc[39:0];
        if (!tx_raw) tx_rd_ff <= tx_enc[40];
      end
    end
  end

  // Check generator from start of frame to its end
  always_ff @(posedge sys_clk_i) begin
    if (tx_rst_ff || !tx_gen) begin
      tx_infr_ff <= 1'b0;
      tx_crc_ff  <= fcedc_pkg::CRC_INIT;
    end else if (tx_take) begin
      if (tx_ins) tx_infr_ff <= 1'b0;
      else if (tx_os[fcedc_pkg::OS_SOF]) begin
        tx_infr_ff <= 1'b1;
        tx_crc_ff  <= fcedc_pkg::CRC_INIT;
      end else if (tx_infr_ff && !(|tx_os))
        tx_crc_ff <= crc_upd(tx_crc_ff, tx_word_in_i);
    end
  end

  // ****************************************
  // Receive path
  // ****************************************
  logic [19:0] rx_in_ff;
  logic [39:0] rx_sr_ff;
  logic [1:0]  rx_ph_ff;
  logic        rx_full_ff, rx_rd_ff, rx_infr_ff;
  logic [31:0] rx_crc_ff;
  fcedc_pkg::fcedc_sync_t sy_ff, nxt_sy;

  // Comma alignment, word assembly and decode
  wire [1:0]  rx_last = narrow_iface_sel_i ? 2'h3 : 2'h1;
  wire [9:0]  rx_top  = narrow_iface_sel_i ? rx_in_ff[9:0] : rx_in_ff[19:10];
  wire        rx_cma  = !rx_bypass_sel_i && (rx_top[9:3] == fcedc_pkg::COMMA_P
                        || rx_top[9:3] == ~fcedc_pkg::COMMA_P);
  wire [1:0]  rx_pcur = rx_cma ? 2'h0 : rx_ph_ff;
  wire fcedc_pkg::fcedc_dec_t rx_dec = dec_word(rx_sr_ff, rx_rd_ff);
  wire [14:0] rx_os   = os_class(rx_dec.w, rx_dec.k, rx_inframe_idle_on_i);
  wire        rx_skip = rx_os[fcedc_pkg::OS_IDLE] && rx_inframe_idle_on_i;
  wire        rx_end  = rx_infr_ff && (|rx_os) && !rx_skip;
  wire        rx_bad  = rx_dec.inv || rx_dec.rderr;
  wire        rx_word = rx_full_ff && !rx_bypass_sel_i;

  // Input capture and shift into the word register
  always_ff @(posedge sys_clk_i) begin
    if (rx_rst_ff) begin
      rx_in_ff   <= '0;
      rx_sr_ff   <= '0;
      rx_ph_ff   <= 2'h0;
      rx_full_ff <= 1'b0;
    end else begin
      rx_in_ff   <= des_chunk_in_i;
      rx_sr_ff   <= narrow_iface_sel_i ? {rx_sr_ff[29:0], rx_in_ff[9:0]}
                                       : {rx_sr_ff[19:0], rx_in_ff};
      rx_ph_ff   <= (rx_pcur == rx_last) ? 2'h0 : rx_pcur + 2'h1;
      rx_full_ff <= rx_pcur == rx_last;
    end
  end

  // Word sync state machine
  always_comb begin
    nxt_sy = sy_ff;
    unique case (sy_ff)
      fcedc_pkg::SY_LOS0: if (rx_bad) nxt_sy = fcedc_pkg::SY_LOS0;
                          else if (rx_dec.k) nxt_sy = fcedc_pkg::SY_LOS1;
      fcedc_pkg::SY_LOS1: if (rx_bad) nxt_sy = fcedc_pkg::SY_LOS0;
                          else if (rx_dec.k) nxt_sy = fcedc_pkg::SY_LOS2;
      fcedc_pkg::SY_LOS2: if (rx_bad) nxt_sy = fcedc_pkg::SY_LOS0;
                          else if (rx_dec.k) nxt_sy = fcedc_pkg::SY_OK;
      fcedc_pkg::SY_OK:   if (rx_bad) nxt_sy = fcedc_pkg::SY_BAD1;
      fcedc_pkg::SY_BAD1: nxt_sy = rx_bad ? fcedc_pkg::SY_BAD2
                                          : fcedc_pkg::SY_OK;
      fcedc_pkg::SY_BAD2: nxt_sy = rx_bad ? fcedc_pkg::SY_BAD3
                                          : fcedc_pkg::SY_OK;
      fcedc_pkg::SY_BAD3: nxt_sy = rx_bad ? fcedc_pkg::SY_LOS0
                                          : fcedc_pkg::SY_OK;
      default:            nxt_sy = fcedc_pkg::SY_LOS0;
    endcase
  end

  // Output word, flags, check result and sync state
  always_ff @(posedge sys_clk_i) begin
    if (rx_rst_ff) begin
      sy_ff <= fcedc_pkg::SY_LOS0;
      sync_lost_flag_o <= 1'b1;
      rx_rd_ff <= 1'b0;
      rx_infr_ff <= 1'b0;
      rx_crc_ff <= fcedc_pkg::CRC_INIT;
      rx_word_valid_o <= 1'b0;
      rx_word_out_o <= '0;
      rx_raw_ext_out_o <= '0;
      rx_special_flag_o <= 1'b0;
      ordered_set_onehot_o <= '0;
      bad_code_flag_o <= 1'b0;
      disparity_error_flag_o <= 1'b0;
      rx_check_done_o <= 1'b0;
      rx_check_good_o <= 1'b0;
    end else begin
      rx_word_valid_o <= rx_full_ff;
      if (rx_full_ff && rx_bypass_sel_i) begin
        {rx_raw_ext_out_o, rx_word_out_o} <= rx_sr_ff;
        rx_special_flag_o <= 1'b0;
        ordered_set_onehot_o <= '0;
        bad_code_flag_o <= 1'b0;
        disparity_error_flag_o <= 1'b0;
        rx_check_done_o <= 1'b0;
        rx_check_good_o <= 1'b0;
        rx_infr_ff <= 1'b0;
      end else if (rx_word) begin
        sy_ff <= nxt_sy;
        sync_lost_flag_o <= nxt_sy < fcedc_pkg::SY_OK;
        rx_rd_ff <= rx_dec.rd;
        rx_word_out_o <= rx_dec.w;
        rx_raw_ext_out_o <= '0;
        rx_special_flag_o <= rx_dec.k;
        ordered_set_onehot_o <= rx_os;
        bad_code_flag_o <= rx_dec.inv;
        disparity_error_flag_o <= rx_dec.rderr;
        rx_check_done_o <= rx_check_on_i && rx_end;
        rx_check_good_o <= rx_check_on_i && rx_end &&
                           rx_crc_ff == '0;
        if (!rx_check_on_i || rx_end) rx_infr_ff <= 1'b0;
        else if (rx_os[fcedc_pkg::OS_SOF]) begin
          rx_infr_ff <= 1'b1;
          rx_crc_ff <= fcedc_pkg::CRC_INIT;
        end else if (rx_infr_ff && !(|rx_os))
          rx_crc_ff <= crc_upd(rx_crc_ff, rx_dec.w);
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign tx_ready_o         = tx_rdy_ff;
  assign tx_taken_o         = tx_tkn_ff;
  assign tx_half_rate_clk_o = tx_hclk_ff;
  assign tx_path_reset_o    = tx_rst_ff;
  assign ser_chunk_out_o    = ser_ff;
  assign rx_half_rate_clk_o = rx_hclk_ff;
  assign rx_path_reset_o    = rx_rst_ff;
  assign sync_state_index_o = sy_ff;
endmodule : fcedc_core
`default_nettype wire

/* fcedc_serdes_model.sv */
// Serializer model that loops transmit pieces back to the receiver
`timescale 1ns/1ps
`default_nettype none
module fcedc_serdes_model (
  // Clock and mode
  input  wire logic        sys_clk_i,
  input  wire logic        narrow_iface_sel_i,
  // Line pieces
  input  wire logic [19:0] ser_chunk_i,
  output logic [19:0]      des_chunk_o
);
  // Loop back in order; unused lanes churn in narrow mode
  always_ff @(posedge sys_clk_i)
    des_chunk_o <= narrow_iface_sel_i ?
                   {~des_chunk_o[19:10], ser_chunk_i[9:0]} : ser_chunk_i;
endmodule : fcedc_serdes_model
`default_nettype wire

/* fcedc_core_properties.sv */
// Concurrent checks on the endec core ports
`timescale 1ns/1ps
`default_nettype none
module fcedc_core_properties (
  // Clock, reset and modes
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        clk_stop_i,
  input wire logic        rx_bypass_sel_i,
  input wire logic        narrow_iface_sel_i,
  // Watched outputs
  input wire logic        tx_ready_o,
  input wire logic        tx_taken_o,
  input wire logic        tx_half_rate_clk_o,
  input wire logic        tx_path_reset_o,
  input wire logic        rx_half_rate_clk_o,
  input wire logic        rx_path_reset_o,
  input wire logic        rx_word_valid_o,
  input wire logic        rx_check_done_o,
  input wire logic        rx_check_good_o,
  input wire logic        sync_lost_flag_o,
  input wire logic [2:0]  sync_state_index_o,
  input wire logic [14:0] ordered_set_onehot_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Clock, reset, sync, check and set relations
  chk_stop_holds: assert property (clk_stop_i |=> $stable(tx_half_rate_clk_o)
    && $stable(rx_half_rate_clk_o)) else $error("half clock moved");
  chk_half_toggle: assert property (!clk_stop_i && !tx_path_reset_o
    && !rx_path_reset_o |=> tx_half_rate_clk_o != $past(tx_half_rate_clk_o)
    && rx_half_rate_clk_o != $past(rx_half_rate_clk_o))
    else $error("half clock stuck");
  chk_reset_release: assert property (disable iff (1'b0) $fell(rst_i)
    |-> tx_path_reset_o && rx_path_reset_o ##[1:3]
    !tx_path_reset_o && !rx_path_reset_o) else $error("path reset late");
  chk_enter_sync: assert property ($fell(sync_lost_flag_o)
    |-> $past(sync_state_index_o) == 3'h2 && sync_state_index_o == 3'h3)
    else $error("bad sync entry");
  chk_lose_sync: assert property ($rose(sync_lost_flag_o)
    |-> $past(sync_state_index_o) == 3'h6 && sync_state_index_o == 3'h0)
    else $error("bad sync loss");
  chk_ins_take: assert property ($fell(tx_ready_o) |-> tx_taken_o)
    else $error("no take at insert");
  chk_done_slot: assert property ($rose(rx_check_done_o) && !narrow_iface_sel_i
    |=> rx_check_done_o ##1 !rx_check_done_o) else $error("done width");
  chk_onehot_sets: assert property ($onehot0(ordered_set_onehot_o))
    else $error("several set lines");
  chk_bypass_quiet: assert property (rx_bypass_sel_i[*8] ##1 rx_word_valid_o
    |-> ordered_set_onehot_o == 15'h0 && !rx_check_done_o)
    else $error("flags in bypass");
  cover property (rx_check_good_o);
  cover property ($fell(sync_lost_flag_o));
  cover property ($rose(sync_lost_flag_o));
endmodule : fcedc_core_properties
bind fcedc_core fcedc_core_properties i_props (.sys_clk_i, .rst_i,
  .clk_stop_i, .rx_bypass_sel_i, .narrow_iface_sel_i, .tx_ready_o,
  .tx_taken_o, .tx_half_rate_clk_o, .tx_path_reset_o,
  .rx_half_rate_clk_o, .rx_path_reset_o, .rx_word_valid_o, .rx_check_done_o,
  .rx_check_good_o, .sync_lost_flag_o, .sync_state_index_o,
  .ordered_set_onehot_o);
`default_nettype wire

/* tb_fc_endec_tx_rx_paths.sv */
// Self-checking testbench for the line coding endec core
`timescale 1ns/1ps
`default_nettype none
module tb_fc_endec_tx_rx_paths;
  logic        sys_clk_i = 1'b0, rst_i = 1'b1, clk_stop_i = 1'b0;
  logic        narrow_iface_sel_i = 1'b0, tx_bypass_sel_i = 1'b0;
  logic        tx_special_flag_i = 1'b0, tx_check_gen_on_i = 1'b0;
  logic        tx_inframe_idle_on_i = 1'b0, rx_inframe_idle_on_i = 1'b0;
  logic        rx_bypass_sel_i = 1'b0, rx_check_on_i = 1'b0;
  logic [31:0] tx_word_in_i = 32'h0, rx_word_out_o;
  logic [7:0]  tx_raw_ext_in_i = 8'h0, rx_raw_ext_out_o;
  logic [19:0] ser_chunk_out_o, des_chunk_in_i;
  logic        tx_taken_o, tx_half_rate_clk_o, rx_word_valid_o, half_was;
  logic        rx_special_flag_o, rx_check_done_o, rx_check_good_o;
  logic        sync_lost_flag_o, bad_code_flag_o, disparity_error_flag_o;
  logic [2:0]  sync_state_index_o;
  logic [14:0] ordered_set_onehot_o;
  int          miscompares = 0, compares = 0;
  localparam logic [31:0] IDLE_W = 32'hbc95b5b5;
  fcedc_core i_dut (.sys_clk_i, .rst_i, .clk_stop_i, .narrow_iface_sel_i,
    .tx_bypass_sel_i, .tx_word_in_i, .tx_raw_ext_in_i, .tx_special_flag_i,
    .tx_check_gen_on_i, .tx_inframe_idle_on_i, .tx_ready_o(), .tx_taken_o,
    .tx_half_rate_clk_o, .tx_path_reset_o(), .ser_chunk_out_o,
    .des_chunk_in_i, .rx_bypass_sel_i, .rx_check_on_i, .rx_inframe_idle_on_i,
    .rx_half_rate_clk_o(), .rx_path_reset_o(), .rx_word_valid_o,
    .rx_word_out_o, .rx_raw_ext_out_o, .rx_special_flag_o, .rx_check_done_o,
    .rx_check_good_o, .sync_lost_flag_o, .sync_state_index_o,
    .ordered_set_onehot_o, .bad_code_flag_o, .disparity_error_flag_o);
  fcedc_serdes_model i_serdes (.sys_clk_i, .narrow_iface_sel_i,
    .ser_chunk_i(ser_chunk_out_o), .des_chunk_o(des_chunk_in_i));
  // Clock
  always #50 sys_clk_i = ~sys_clk_i;
  task automatic close_out;
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic hang;
    miscompares++;
    close_out();
  endtask : hang
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // Offer a word and hold it until a later take
  task automatic send(input logic [31:0] d, input logic k);
    int n;
    tx_word_in_i <= d;
    tx_special_flag_i <= k;
    for (n = 0; n < 12; n++) begin
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      if (tx_taken_o === 1'b1) break;
    end
    if (n == 12) hang();
    @(posedge sys_clk_i);
  endtask : send
  // Wait for a decoded word and check it with its flags
  task automatic expect_rx(input logic [31:0] d, input logic [7:0] e,
                           input logic k, input logic [14:0] os);
    int n;
    for (n = 0; n < 99; n++) begin
      @(negedge sys_clk_i);
      if (rx_word_valid_o === 1'b1 && rx_word_out_o === d) break;
    end
    if (n == 99) hang();
    cmp({rx_raw_ext_out_o, rx_word_out_o}, {e, d});
    cmp({rx_special_flag_o, bad_code_flag_o, disparity_error_flag_o,
         ordered_set_onehot_o}, {k, 2'h0, os});
    @(posedge sys_clk_i);
  endtask : expect_rx
  initial begin
    int n;
    for (int m = 0; m < 2; m++) begin
      narrow_iface_sel_i <= m[0];
      rst_i <= 1'b1;
      repeat (6) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      cmp({sync_lost_flag_o, sync_state_index_o}, 4'h8);
      @(posedge sys_clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      send(IDLE_W, 1'b1);
      repeat (4) expect_rx(IDLE_W, 8'h0, 1'b1, 15'h4);
      @(negedge sys_clk_i);
      cmp({sync_lost_flag_o, sync_state_index_o}, 4'h3);
      @(posedge sys_clk_i);
      send(32'h0123abcd, 1'b0);
      expect_rx(32'h0123abcd, 8'h0, 1'b0, 15'h0);
      for (int g = 1; g >= 0; g--) begin
        tx_check_gen_on_i <= g[0];
        rx_check_on_i <= 1'b1;
        tx_inframe_idle_on_i <= 1'b1;
        rx_inframe_idle_on_i <= 1'b1;
        send(32'hbcb51717, 1'b1);
        send(32'h11223344, 1'b0);
        send(IDLE_W, 1'b1);
        send(32'h55667788, 1'b0);
        send(32'hbc957575, 1'b1);
        send(IDLE_W, 1'b1);
        for (n = 0; n < 60 && rx_check_done_o !== 1'b1; n++)
          @(negedge sys_clk_i);
        if (n == 60) hang();
        cmp({rx_check_done_o, rx_check_good_o}, {1'b1, g[0]});
        @(posedge sys_clk_i);
      end
      tx_bypass_sel_i <= 1'b1;
      rx_bypass_sel_i <= 1'b1;
      tx_raw_ext_in_i <= 8'ha5;
      send(32'h5a5a5a5a, 1'b0);
      expect_rx(32'h5a5a5a5a, 8'ha5, 1'b0, 15'h0);
      rx_bypass_sel_i <= 1'b0;
      tx_word_in_i <= 32'h0;
      tx_raw_ext_in_i <= 8'h0;
      for (n = 0; n < 99 && sync_lost_flag_o !== 1'b1; n++)
        @(negedge sys_clk_i);
      if (n == 99) hang();
      cmp({sync_lost_flag_o, bad_code_flag_o}, 2'h3);
      @(posedge sys_clk_i);
      tx_bypass_sel_i <= 1'b0;
      clk_stop_i <= 1'b1;
      @(negedge sys_clk_i);
      half_was = tx_half_rate_clk_o;
      repeat (2) @(negedge sys_clk_i);
      cmp(tx_half_rate_clk_o, half_was);
      @(posedge sys_clk_i);
      clk_stop_i <= 1'b0;
    end
    close_out();
  end
endmodule : tb_fc_endec_tx_rx_paths
`default_nettype wire
